// ===== shared/dma_regs_pkg.sv
`default_nettype none
package dma_regs_pkg;

  // ---------------------------------------------------------------
  // Register map (byte offsets, one aligned word each)
  // ---------------------------------------------------------------
  localparam logic [7:0] STATUS_OFS      = 8'h00;
  localparam logic [7:0] ADDRESS_OFS     = 8'h04;
  localparam logic [7:0] CHAN_BASE_OFS   = 8'h10;
  localparam logic [7:0] CHAN_STRIDE     = 8'h10;
  localparam logic [7:0] SRC_LEN_OFS     = 8'h00;
  localparam logic [7:0] DST_LEN_OFS     = 8'h04;

  // ---------------------------------------------------------------
  // Field layout and reset values
  // ---------------------------------------------------------------
  localparam int          DIR_BIT        = 3;
  localparam int          CHAN_LSB       = 0;
  localparam int          CHAN_W         = 3;
  localparam int          LEN_W          = 16;
  localparam logic [31:0] WORD_RESET     = 32'h0000_0000;
  localparam logic [15:0] LEN_RESET      = 16'h0000;
  localparam logic [31:0] UNMAPPED_DATA  = 32'h0000_0000;

  // Snapshot of one DMA bus access as seen by the status logic
  typedef struct packed {
    logic        is_read;
    logic [2:0]  channel;
    logic [31:0] address;
  } access_t;

endpackage
`default_nettype wire

// ===== hdl/access_capture.sv
`timescale 1ns/10ps
`default_nettype none
// -----------------------------------------------------------------
// Last-access capture
// -----------------------------------------------------------------
module access_capture (
  input  wire logic                 clk_i,     // System clock
  input  wire logic                 rst_n_i,   // Async reset, low
  input  wire logic                 valid_i,   // Transfer strobe
  input  wire dma_regs_pkg::access_t acc_i,    // Transfer details
  output var  dma_regs_pkg::access_t last_o    // Held snapshot
);

  dma_regs_pkg::access_t last_ff;

  // One register for all fields keeps them describing one access
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      last_ff <= '0;
    end else if (valid_i) begin
      last_ff <= acc_i;
    end
  end

  assign last_o = last_ff;

  capture_whole_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    valid_i |=> (last_ff == $past(acc_i)))
    else $error("Access snapshot not captured whole");

  hold_idle_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    !valid_i |=> $stable(last_ff))
    else $error("Access snapshot changed without transfer");

endmodule
`default_nettype wire

// ===== hdl/dma_status_regs.sv
// The address-and-strobe port and the register offsets were decided locally.
`timescale 1ns/10ps
`default_nettype none
module dma_status_regs #(
  parameter int CHANNELS = 8
) (
  input  wire logic        REF_CLK_I,    // 25 MHz system clock
  input  wire logic        RESET_N_I,    // Async reset, low
  input  wire logic [7:0]  ADDR_I,       // Register byte address
  input  wire logic [31:0] WDATA_I,      // Write data
  input  wire logic        WR_I,         // Write strobe
  input  wire logic        RD_I,         // Read strobe
  output logic      [31:0] RDATA_O,      // Read data, cycle after RD_I
  input  wire logic        XFER_VALID_I, // DMA bus transfer strobe
  input  wire logic        XFER_READ_I,  // Transfer is a read
  input  wire logic [2:0]  XFER_CHAN_I,  // Channel doing the transfer
  input  wire logic [31:0] XFER_ADDR_I,  // Transfer address
  output logic [CHANNELS*16-1:0] SRC_LEN_O, // Source byte counts
  output logic [CHANNELS*16-1:0] DST_LEN_O  // Destination byte counts
);

  // ---------------------------------------------------------------
  // Address decode
  // ---------------------------------------------------------------
  function automatic logic chan_hit(input logic [7:0] a, input int ch, input logic [7:0] ofs);
    logic [7:0] base;
    base = 8'(dma_regs_pkg::CHAN_BASE_OFS + dma_regs_pkg::CHAN_STRIDE * ch);
    return a == 8'(base + ofs);
  endfunction

  function automatic logic [31:0] status_word(input dma_regs_pkg::access_t s);
    logic [31:0] w;
    w = dma_regs_pkg::WORD_RESET;
    w[dma_regs_pkg::DIR_BIT] = s.is_read;
    w[dma_regs_pkg::CHAN_LSB +: dma_regs_pkg::CHAN_W] = s.channel;
    return w;
  endfunction

  // Upper half is never stored, so it is rebuilt as zero on each read
  function automatic logic [31:0] len_word(input logic [15:0] len);
    return {16'h0000, len};
  endfunction

  // First and last channel words, watched by the checks
  localparam logic [7:0] SRC_FIRST_OFS = 8'(dma_regs_pkg::CHAN_BASE_OFS
                                           + dma_regs_pkg::SRC_LEN_OFS);
  localparam logic [7:0] DST_FIRST_OFS = 8'(dma_regs_pkg::CHAN_BASE_OFS
                                           + dma_regs_pkg::DST_LEN_OFS);
  localparam logic [7:0] SRC_LAST_OFS  = 8'(dma_regs_pkg::CHAN_BASE_OFS
    + dma_regs_pkg::CHAN_STRIDE * (CHANNELS - 1) + dma_regs_pkg::SRC_LEN_OFS);
  localparam logic [7:0] DST_LAST_OFS  = 8'(dma_regs_pkg::CHAN_BASE_OFS
    + dma_regs_pkg::CHAN_STRIDE * (CHANNELS - 1) + dma_regs_pkg::DST_LEN_OFS);

  // ---------------------------------------------------------------
  // Word select
  // ---------------------------------------------------------------
  logic                status_sel;
  logic                address_sel;
  logic [CHANNELS-1:0] src_sel;
  logic [CHANNELS-1:0] dst_sel;

  // One decode feeds both the write and the read path
  always_comb begin
    status_sel  = (ADDR_I == dma_regs_pkg::STATUS_OFS);
    address_sel = (ADDR_I == dma_regs_pkg::ADDRESS_OFS);
    for (int i = 0; i < CHANNELS; i++) begin
      src_sel[i] = chan_hit(ADDR_I, i, dma_regs_pkg::SRC_LEN_OFS);
      dst_sel[i] = chan_hit(ADDR_I, i, dma_regs_pkg::DST_LEN_OFS);
    end
  end

  // ---------------------------------------------------------------
  // Transfer capture
  // ---------------------------------------------------------------
  dma_regs_pkg::access_t acc;
  dma_regs_pkg::access_t last;

  assign acc.is_read = XFER_READ_I;
  assign acc.channel = XFER_CHAN_I;
  assign acc.address = XFER_ADDR_I;

  access_capture u_capture (
    .clk_i   (REF_CLK_I),
    .rst_n_i (RESET_N_I),
    .valid_i (XFER_VALID_I),
    .acc_i   (acc),
    .last_o  (last)
  );

  // ---------------------------------------------------------------
  // Channel length registers
  // ---------------------------------------------------------------
  logic [15:0] src_len_ff [CHANNELS];
  logic [15:0] dst_len_ff [CHANNELS];

  // Source and destination counts kept in separate processes
  always_ff @(posedge REF_CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      for (int i = 0; i < CHANNELS; i++) begin
        src_len_ff[i] <= dma_regs_pkg::LEN_RESET;
      end
    end else if (WR_I) begin
      for (int i = 0; i < CHANNELS; i++) begin
        if (src_sel[i]) begin
          src_len_ff[i] <= WDATA_I[15:0];
        end
      end
    end
  end

  always_ff @(posedge REF_CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      for (int i = 0; i < CHANNELS; i++) begin
        dst_len_ff[i] <= dma_regs_pkg::LEN_RESET;
      end
    end else if (WR_I) begin
      for (int i = 0; i < CHANNELS; i++) begin
        if (dst_sel[i]) begin
          dst_len_ff[i] <= WDATA_I[15:0];
        end
      end
    end
  end

  // Outputs straight from the length flops
  always_comb begin
    for (int i = 0; i < CHANNELS; i++) begin
      SRC_LEN_O[i*16 +: 16] = src_len_ff[i];
      DST_LEN_O[i*16 +: 16] = dst_len_ff[i];
    end
  end

  // ---------------------------------------------------------------
  // Read path
  // ---------------------------------------------------------------
  logic [31:0] nxt_rdata;
  logic [31:0] rdata_ff;

  always_comb begin
    nxt_rdata = dma_regs_pkg::UNMAPPED_DATA;
    if (status_sel) begin
      nxt_rdata = status_word(last);
    end else if (address_sel) begin
      nxt_rdata = last.address;
    end
    for (int i = 0; i < CHANNELS; i++) begin
      if (src_sel[i]) begin
        nxt_rdata = len_word(src_len_ff[i]);
      end
      if (dst_sel[i]) begin
        nxt_rdata = len_word(dst_len_ff[i]);
      end
    end
  end

  // Data stands only in the cycle after the strobe
  always_ff @(posedge REF_CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      rdata_ff <= dma_regs_pkg::WORD_RESET;
    end else if (RD_I) begin
      rdata_ff <= nxt_rdata;
    end else begin
      rdata_ff <= dma_regs_pkg::WORD_RESET;
    end
  end

  assign RDATA_O = rdata_ff;

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  // Transfer followed by a clean read of the snapshot
  sequence status_after_xfer_s;
    XFER_VALID_I ##1 (RD_I && ADDR_I == dma_regs_pkg::STATUS_OFS && !XFER_VALID_I);
  endsequence

  sequence address_after_xfer_s;
    XFER_VALID_I ##1 (RD_I && ADDR_I == dma_regs_pkg::ADDRESS_OFS && !XFER_VALID_I);
  endsequence

  // Write immediately followed by a read of the same word
  sequence src_write_read_s;
    (WR_I && ADDR_I == SRC_FIRST_OFS) ##1 (RD_I && ADDR_I == SRC_FIRST_OFS);
  endsequence

  sequence dst_write_read_s;
    (WR_I && ADDR_I == DST_FIRST_OFS) ##1 (RD_I && ADDR_I == DST_FIRST_OFS);
  endsequence

  // Two edges in reset so that the clear has surely landed
  sequence held_in_reset_s;
    !RESET_N_I ##1 !RESET_N_I;
  endsequence

  status_upper_a: assert property (@(posedge REF_CLK_I) disable iff (!RESET_N_I)
    (RD_I && ADDR_I == dma_regs_pkg::STATUS_OFS) |=> RDATA_O[31:4] == 28'h0000000)
    else $error("Status upper bits not zero");

  status_dir_a: assert property (@(posedge REF_CLK_I) disable iff (!RESET_N_I)
    status_after_xfer_s |=> RDATA_O[3] == $past(XFER_READ_I, 2))
    else $error("Direction flag wrong");

  status_chan_a: assert property (@(posedge REF_CLK_I) disable iff (!RESET_N_I)
    status_after_xfer_s |=> RDATA_O[2:0] == $past(XFER_CHAN_I, 2))
    else $error("Channel field wrong");

  status_live_a: assert property (@(posedge REF_CLK_I) disable iff (!RESET_N_I)
    (RD_I && ADDR_I == dma_regs_pkg::STATUS_OFS)
      |=> RDATA_O[3:0] == $past({last.is_read, last.channel}))
    else $error("Status read does not show held snapshot");

  addr_read_a: assert property (@(posedge REF_CLK_I) disable iff (!RESET_N_I)
    address_after_xfer_s |=> RDATA_O == $past(XFER_ADDR_I, 2))
    else $error("Captured address wrong");

  addr_live_a: assert property (@(posedge REF_CLK_I) disable iff (!RESET_N_I)
    (RD_I && ADDR_I == dma_regs_pkg::ADDRESS_OFS) |=> RDATA_O == $past(last.address))
    else $error("Address read does not show held snapshot");

  src_write_a: assert property (@(posedge REF_CLK_I) disable iff (!RESET_N_I)
    src_write_read_s |=> RDATA_O == {16'h0000, $past(WDATA_I[15:0], 2)})
    else $error("Source length readback wrong");

  src_upper_a: assert property (@(posedge REF_CLK_I) disable iff (!RESET_N_I)
    (RD_I && ADDR_I == SRC_FIRST_OFS) |=> RDATA_O[31:16] == 16'h0000)
    else $error("Source length upper bits not zero");

  dst_write_a: assert property (@(posedge REF_CLK_I) disable iff (!RESET_N_I)
    dst_write_read_s |=> RDATA_O == {16'h0000, $past(WDATA_I[15:0], 2)})
    else $error("Destination length readback wrong");

  dst_upper_a: assert property (@(posedge REF_CLK_I) disable iff (!RESET_N_I)
    (RD_I && ADDR_I == DST_FIRST_OFS) |=> RDATA_O[31:16] == 16'h0000)
    else $error("Destination length upper bits not zero");

  src_out_a: assert property (@(posedge REF_CLK_I) disable iff (!RESET_N_I)
    (WR_I && ADDR_I == SRC_FIRST_OFS) |=> SRC_LEN_O[15:0] == $past(WDATA_I[15:0]))
    else $error("Source length output not updated");

  src_last_out_a: assert property (@(posedge REF_CLK_I) disable iff (!RESET_N_I)
    (WR_I && ADDR_I == SRC_LAST_OFS)
      |=> SRC_LEN_O[CHANNELS*16-1 -: 16] == $past(WDATA_I[15:0]))
    else $error("Last channel source length not updated");

  dst_out_a: assert property (@(posedge REF_CLK_I) disable iff (!RESET_N_I)
    (WR_I && ADDR_I == DST_FIRST_OFS) |=> DST_LEN_O[15:0] == $past(WDATA_I[15:0]))
    else $error("Destination length output not updated");

  dst_last_out_a: assert property (@(posedge REF_CLK_I) disable iff (!RESET_N_I)
    (WR_I && ADDR_I == DST_LAST_OFS)
      |=> DST_LEN_O[CHANNELS*16-1 -: 16] == $past(WDATA_I[15:0]))
    else $error("Last channel destination length not updated");

  src_hold_a: assert property (@(posedge REF_CLK_I) disable iff (!RESET_N_I)
    !WR_I |=> $stable(SRC_LEN_O))
    else $error("Source lengths changed without write");

  dst_hold_a: assert property (@(posedge REF_CLK_I) disable iff (!RESET_N_I)
    !WR_I |=> $stable(DST_LEN_O))
    else $error("Destination lengths changed without write");

  status_ro_a: assert property (@(posedge REF_CLK_I) disable iff (!RESET_N_I)
    (WR_I && ADDR_I == dma_regs_pkg::STATUS_OFS && !XFER_VALID_I) |=> $stable(last))
    else $error("Status changed by a register write");

  addr_ro_a: assert property (@(posedge REF_CLK_I) disable iff (!RESET_N_I)
    (WR_I && ADDR_I == dma_regs_pkg::ADDRESS_OFS && !XFER_VALID_I)
      |=> $stable(last.address))
    else $error("Address changed by a register write");

  decode_onehot_a: assert property (@(posedge REF_CLK_I) disable iff (!RESET_N_I)
    $onehot0({status_sel, address_sel, src_sel, dst_sel}))
    else $error("Register decode selects more than one word");

  unmapped_read_a: assert property (@(posedge REF_CLK_I) disable iff (!RESET_N_I)
    (RD_I && !status_sel && !address_sel && src_sel == '0 && dst_sel == '0)
      |=> RDATA_O == dma_regs_pkg::UNMAPPED_DATA)
    else $error("Unmapped read returned data");

  rdata_idle_a: assert property (@(posedge REF_CLK_I) disable iff (!RESET_N_I)
    !RD_I |=> RDATA_O == dma_regs_pkg::WORD_RESET)
    else $error("Read data present without a read");

  reset_zero_a: assert property (@(posedge REF_CLK_I)
    held_in_reset_s |-> (last == '0 && RDATA_O == dma_regs_pkg::WORD_RESET
                         && SRC_LEN_O == '0 && DST_LEN_O == '0))
    else $error("Registers not cleared in reset");

  status_addr_a: assert property (@(posedge REF_CLK_I) disable iff (!RESET_N_I)
    XFER_VALID_I |=> (last.address == $past(XFER_ADDR_I)
                      && last.channel == $past(XFER_CHAN_I)
                      && last.is_read == $past(XFER_READ_I)))
    else $error("Status and address not updated together");

endmodule
`default_nettype wire

// ===== testbench/testbench.sv
`timescale 1ns/10ps
`default_nettype none
module testbench;
  localparam int CH = 8;
  logic                 clk, rst_n, wr, rd, xv, xr, rd_seen;
  logic [7:0]           addr;
  logic [31:0]          wdata, xa, rdata, st_m, ad_m, v;
  logic [2:0]           xc;
  logic [CH*16-1:0]     src_len, dst_len;
  logic [15:0]          src_m [CH];
  logic [15:0]          dst_m [CH];
  logic [31:0]          exp_q [$];
  int                   err_total, n_tests;

  dma_status_regs #(.CHANNELS(CH)) dut (.REF_CLK_I(clk), .RESET_N_I(rst_n), .ADDR_I(addr),
    .WDATA_I(wdata), .WR_I(wr), .RD_I(rd), .RDATA_O(rdata), .XFER_VALID_I(xv),
    .XFER_READ_I(xr), .XFER_CHAN_I(xc), .XFER_ADDR_I(xa), .SRC_LEN_O(src_len),
    .DST_LEN_O(dst_len));

  // ---------------------------------------------------------------
  // Clock, checks, watchdog
  // ---------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      err_total++;
      $display("Error %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic end_sim();
    if (err_total == 0 && n_tests > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  // Read data stands only in the cycle after the strobe
  always @(posedge clk) rd_seen <= rd;
  always @(negedge clk) begin
    if (rd_seen === 1'b1) begin
      if (exp_q.size() == 0) chk(rdata, 32'hDEAD_BEEF);
      else chk(rdata, exp_q.pop_front());
    end
  end

  initial begin
    #(40 * 4000);
    err_total++;
    end_sim();
  end

  // ---------------------------------------------------------------
  // Bus tasks
  // ---------------------------------------------------------------
  function automatic logic [7:0] ofs(input int i, input logic [7:0] f);
    return dma_regs_pkg::CHAN_BASE_OFS + dma_regs_pkg::CHAN_STRIDE * 8'(i) + f;
  endfunction

  task automatic drive(input logic w, input logic r, input logic x, input logic [7:0] a,
                       input logic [31:0] d);
    @(posedge clk);
    wr <= w; rd <= r; xv <= x; addr <= a; wdata <= d;
  endtask

  task automatic rd_t(input logic [7:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    drive(1'b0, 1'b1, 1'b0, a, $urandom);
  endtask

  task automatic xf_t();
    v = $urandom;
    drive(1'b0, 1'b0, 1'b1, 8'h00, 32'h0000_0000);
    xr <= v[0]; xc <= v[3:1]; xa <= $urandom ^ v;
    #1 st_m = {28'h0, v[0], v[3:1]};
    ad_m = xa;
  endtask

  task automatic rd_all();
    rd_t(dma_regs_pkg::STATUS_OFS, st_m);
    rd_t(dma_regs_pkg::ADDRESS_OFS, ad_m);
    for (int i = 0; i < CH; i++) begin
      rd_t(ofs(i, dma_regs_pkg::SRC_LEN_OFS), {16'h0, src_m[i]});
      rd_t(ofs(i, dma_regs_pkg::DST_LEN_OFS), {16'h0, dst_m[i]});
    end
  endtask

  // ---------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------
  initial begin
    rst_n = 1'b0; wr = 1'b0; rd = 1'b0; xv = 1'b0; xr = 1'b0; xc = 3'h0;
    addr = 8'h00; wdata = 32'h0; xa = 32'h0; err_total = 0; n_tests = 0;
    st_m = 32'h0; ad_m = 32'h0;
    for (int i = 0; i < CH; i++) begin
      src_m[i] = 16'h0; dst_m[i] = 16'h0;
    end
    void'($urandom(20));
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    rd_all();
    // Upper halves written with junk, back to back
    for (int i = 0; i < CH; i++) begin
      v = $urandom; src_m[i] = v[15:0];
      drive(1'b1, 1'b0, 1'b0, ofs(i, dma_regs_pkg::SRC_LEN_OFS), v);
      v = $urandom; dst_m[i] = v[15:0];
      drive(1'b1, 1'b0, 1'b0, ofs(i, dma_regs_pkg::DST_LEN_OFS), v);
    end
    drive(1'b1, 1'b0, 1'b0, ofs(CH - 1, dma_regs_pkg::SRC_LEN_OFS), 32'hFFFF_FFFF);
    src_m[CH - 1] = 16'hFFFF;
    // Read-only words must ignore writes
    drive(1'b1, 1'b0, 1'b0, dma_regs_pkg::STATUS_OFS, 32'hFFFF_FFFF);
    drive(1'b1, 1'b0, 1'b0, dma_regs_pkg::ADDRESS_OFS, $urandom);
    drive(1'b0, 1'b0, 1'b0, 8'h00, 32'h0);
    @(negedge clk);
    for (int i = 0; i < CH; i++) begin
      chk({16'h0, src_len[i*16+:16]}, {16'h0, src_m[i]});
      chk({16'h0, dst_len[i*16+:16]}, {16'h0, dst_m[i]});
    end
    rd_all();
    // Bursts of transfers; only the last one may show
    repeat (20) begin
      repeat ($urandom % 3 + 1) xf_t();
      rd_t(dma_regs_pkg::STATUS_OFS, st_m);
      rd_t(dma_regs_pkg::ADDRESS_OFS, ad_m);
    end
    // Write then read the same word at once, first channel
    v = $urandom;
    src_m[0] = v[15:0];
    drive(1'b1, 1'b0, 1'b0, ofs(0, dma_regs_pkg::SRC_LEN_OFS), v);
    rd_t(ofs(0, dma_regs_pkg::SRC_LEN_OFS), {16'h0, src_m[0]});
    v = $urandom;
    dst_m[0] = v[15:0];
    drive(1'b1, 1'b0, 1'b0, ofs(0, dma_regs_pkg::DST_LEN_OFS), v);
    rd_t(ofs(0, dma_regs_pkg::DST_LEN_OFS), {16'h0, dst_m[0]});
    // Mid-run reset; one idle edge first so the last read data is seen
    drive(1'b0, 1'b0, 1'b0, 8'h00, 32'h0);
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    st_m = 32'h0;
    ad_m = 32'h0;
    for (int i = 0; i < CH; i++) begin
      src_m[i] = 16'h0;
      dst_m[i] = 16'h0;
    end
    rd_all();
    rd_t(8'hFC, dma_regs_pkg::UNMAPPED_DATA);
    rd_t(8'h08, dma_regs_pkg::UNMAPPED_DATA);
    drive(1'b0, 1'b0, 1'b0, 8'h00, 32'h0);
    repeat (3) @(posedge clk);
    if (exp_q.size() != 0) chk(32'h0, 32'h1);
    end_sim();
  end
endmodule
`default_nettype wire
